// [hw/qdb_fifo.sv]
/*
 * Synchronous FIFO with valid and ready on both sides and a fill level.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module qdb_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH):0]          level
);
    import qdb_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // ------------------------------------------------------------
    // Pointer and count update.
    // ------------------------------------------------------------
    always_comb begin
        in_ready  = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        cnt_d     = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        out_data = mem[rd_q];
        level    = cnt_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

// [hw/qdb_link_if.sv]
/*
 * Link between the driving end and the capturing end.
 * Assumes only the driving end enables the shared lines; released
 * lines are pulled high, as by bus termination.
 */
`timescale 1ns/100ps
interface qdb_link_if;
    import qdb_pkg::*;

    logic      link_clk;
    qdb_word_t data_out;
    qdb_grp_t  flag_out;
    logic      valid_out;
    qdb_grp_t  pos_out;
    qdb_grp_t  neg_out;
    logic      bus_oe;
    qdb_word_t data_line;
    qdb_grp_t  flag_line;
    logic      valid_line;
    qdb_grp_t  pos_line;
    qdb_grp_t  neg_line;

    // ------------------------------------------------------------
    // Wire levels from driver and pull-up.
    // ------------------------------------------------------------
    assign data_line  = bus_oe ? data_out  : LINE_IDLE;
    assign flag_line  = bus_oe ? flag_out  : GRP_IDLE;
    assign valid_line = bus_oe ? valid_out : BIT_IDLE;
    assign pos_line   = bus_oe ? pos_out   : GRP_IDLE;
    assign neg_line   = bus_oe ? neg_out   : GRP_IDLE;

    modport tx_mp (
        output link_clk,
        output data_out,
        output flag_out,
        output valid_out,
        output pos_out,
        output neg_out,
        output bus_oe
    );

    modport rx_mp (
        input link_clk,
        input data_line,
        input flag_line,
        input valid_line,
        input pos_line,
        input neg_line
    );
endinterface

// [hw/qdb_pkg.sv]
/*
 * Shared constants and types for the quad-pumped data bus with
 * per-group bus inversion: widths, strobe patterns, reset values.
 * Assumes both bus ends and the FIFO import this package.
 */
// Overview of operation
// - 64-bit shared active-low data lines
// - driver asserts valid flag each transfer
// - four data beats per transfer, one per link clock
// - capture on falling edges of both strobes
// - group g bits pair with strobe/flag g
// - flagged group is inverted back by receiver
// - invert group when over half bits toggle
//
package qdb_pkg;

    // ------------------------------------------------------------
    // Widths and counts.
    // ------------------------------------------------------------
    localparam int DATA_W     = 64;
    localparam int GRP_W      = 16;
    localparam int NUM_GRP    = 4;
    localparam int BEATS      = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int LVL_W      = 6;

    typedef logic [DATA_W-1:0]  qdb_word_t;
    typedef logic [NUM_GRP-1:0] qdb_grp_t;
    typedef logic [1:0]         qdb_beat_t;
    typedef logic [4:0]         qdb_cnt_t;
    typedef logic [LVL_W-1:0]   qdb_lvl_t;

    // ------------------------------------------------------------
    // Decision and sequencing constants.
    // ------------------------------------------------------------
    localparam qdb_cnt_t  INV_LIMIT     = 5'h08;
    localparam qdb_lvl_t  START_LEVEL   = 6'h04;
    localparam qdb_beat_t BEAT_FIRST    = 2'h0;
    localparam logic [3:0] POS_LOW_BEATS = 4'h5;
    localparam logic [3:0] NEG_LOW_BEATS = 4'hA;

    // ------------------------------------------------------------
    // Line levels when released and values after reset.
    // ------------------------------------------------------------
    localparam qdb_word_t LINE_IDLE = 64'hFFFFFFFFFFFFFFFF;
    localparam qdb_grp_t  GRP_IDLE  = 4'hF;
    localparam logic      BIT_IDLE  = 1'h1;
    localparam logic      LCLK_RST  = 1'h0;
    localparam qdb_word_t WORD_RST  = 64'h0000000000000000;

endpackage

// [hw/qdb_rx_end.sv]
/*
 * Capturing end of the quad-pumped data bus, clocked by the link clock.
 * Link lines pass two flip-flops, strobe falling edges pick the beats,
 * flagged groups are inverted back, and each beat leaves as one word.
 * Assumes the driver changes lines on falling link clock edges.
 */
`timescale 1ns/100ps
module qdb_rx_end (
    input  wire logic                rst_b,
    qdb_link_if.rx_mp                link,
    output logic                     out_valid,
    output qdb_pkg::qdb_word_t       out_data,
    output qdb_pkg::qdb_beat_t       out_beat
);
    import qdb_pkg::*;

    localparam int LW = DATA_W + 3*NUM_GRP + 1;

    logic [LW-1:0] s1_q, s2_q;
    qdb_word_t     s_data;
    qdb_grp_t      s_flag, s_pos, s_neg;
    logic          s_valid;
    qdb_grp_t      ppos_q, pneg_q;
    qdb_grp_t      cap;
    qdb_beat_t     cnt_q, cnt_d;
    logic          ov_d;
    qdb_word_t     od_d;
    qdb_beat_t     ob_d;

    assign {s_data, s_flag, s_valid, s_pos, s_neg} = s2_q;

    // ------------------------------------------------------------
    // Beat capture and recovery.
    // ------------------------------------------------------------
    always_comb begin
        cap   = (ppos_q & ~s_pos) | (pneg_q & ~s_neg);
        ov_d  = cap[0] && !s_valid;
        od_d  = out_data;
        ob_d  = out_beat;
        cnt_d = s_valid ? BEAT_FIRST : cnt_q;
        for (int g = 0; g < NUM_GRP; g++) begin
            if (cap[g] && !s_valid) begin
                od_d[g*GRP_W +: GRP_W] = ~s_data[g*GRP_W +: GRP_W]
                    ^ {GRP_W{~s_flag[g]}};
            end
        end
        if (ov_d) begin
            ob_d  = cnt_q;
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q      <= '1;
            s2_q      <= '1;
            ppos_q    <= GRP_IDLE;
            pneg_q    <= GRP_IDLE;
            cnt_q     <= BEAT_FIRST;
            out_valid <= 1'b0;
            out_data  <= WORD_RST;
            out_beat  <= BEAT_FIRST;
        end else begin
            s1_q      <= {link.data_line, link.flag_line,
                          link.valid_line, link.pos_line,
                          link.neg_line};
            s2_q      <= s1_q;
            ppos_q    <= s_pos;
            pneg_q    <= s_neg;
            cnt_q     <= cnt_d;
            out_valid <= ov_d;
            out_data  <= od_d;
            out_beat  <= ob_d;
        end
    end
endmodule

// [hw/qdb_tx_end.sv]
/*
 * Driving end of the quad-pumped data bus. Words from the user pass a
 * FIFO, then go out one word per beat, four beats per transfer, one beat per link clock, with per-group
 * inversion, a valid flag and strobe pairs. The link clock is made
 * here by halving core_clk and driven out on the link.
 * Assumes the capturing end samples on rising link clock edges.
 */
`timescale 1ns/100ps
module qdb_tx_end (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire qdb_pkg::qdb_word_t in_data,
    output logic                   busy,
    qdb_link_if.tx_mp              link
);
    import qdb_pkg::*;

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        QDB_IDLE,
        QDB_SEND
    } qdb_tx_state_t;

    qdb_tx_state_t st_q, st_d;
    logic          lclk_q, lclk_d;
    qdb_beat_t     beat_q, beat_d;
    qdb_word_t     line_q, line_d;
    qdb_grp_t      flag_q, flag_d;
    logic          valid_q, valid_d;
    qdb_grp_t      pos_q, pos_d;
    qdb_grp_t      neg_q, neg_d;
    logic          oe_q, oe_d;

    logic          f_valid;
    logic          f_pop;
    qdb_word_t     f_data;
    qdb_lvl_t      f_level;

    logic          launch;
    logic          start;
    logic          send;
    qdb_word_t     cand;
    qdb_word_t     coded;
    qdb_grp_t      inv;
    qdb_cnt_t      tog [NUM_GRP];

    // ------------------------------------------------------------
    // Word buffer.
    // ------------------------------------------------------------
    qdb_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_b     (rst_b),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data),
        .level     (f_level)
    );

    // ------------------------------------------------------------
    // Inversion decision per group for the next beat.
    // ------------------------------------------------------------
    always_comb begin
        cand = ~f_data;
        for (int g = 0; g < NUM_GRP; g++) begin
            tog[g] = '0;
            for (int b = 0; b < GRP_W; b++) begin
                tog[g] = tog[g] + qdb_cnt_t'(
                    line_q[g*GRP_W+b] ^ cand[g*GRP_W+b]);
            end
            inv[g] = (tog[g] > INV_LIMIT);
            coded[g*GRP_W +: GRP_W] =
                cand[g*GRP_W +: GRP_W] ^ {GRP_W{inv[g]}};
        end
    end

    // ------------------------------------------------------------
    // Beat sequencer.
    // ------------------------------------------------------------
    always_comb begin
        launch  = lclk_q;
        start   = (f_level >= START_LEVEL) && f_valid;
        send    = 1'b0;
        st_d    = st_q;
        beat_d  = beat_q;
        valid_d = valid_q;
        pos_d   = pos_q;
        neg_d   = neg_q;
        oe_d    = oe_q;
        case (st_q)
            QDB_IDLE: begin
                if (launch && start) begin
                    send = 1'b1;
                end
            end
            QDB_SEND: begin
                if (launch) begin
                    send = (beat_q != BEAT_FIRST) || start;
                end
            end
            default: begin
                send = 1'b0;
            end
        endcase
        if (launch && send) begin
            st_d    = QDB_SEND;
            beat_d  = beat_q + 1'b1;
            valid_d = 1'b0;
            pos_d   = {NUM_GRP{~POS_LOW_BEATS[beat_q]}};
            neg_d   = {NUM_GRP{~NEG_LOW_BEATS[beat_q]}};
            oe_d    = 1'b1;
        end else if (launch) begin
            st_d    = QDB_IDLE;
            beat_d  = BEAT_FIRST;
            valid_d = BIT_IDLE;
            pos_d   = GRP_IDLE;
            neg_d   = GRP_IDLE;
            oe_d    = 1'b0;
        end
        f_pop = send;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q    <= QDB_IDLE;
            beat_q  <= BEAT_FIRST;
            valid_q <= BIT_IDLE;
            pos_q   <= GRP_IDLE;
            neg_q   <= GRP_IDLE;
            oe_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            beat_q  <= beat_d;
            valid_q <= valid_d;
            pos_q   <= pos_d;
            neg_q   <= neg_d;
            oe_q    <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // Link clock divider.
    // ------------------------------------------------------------
    // Lines change as this clock falls, midway between its rises.
    always_comb begin
        lclk_d = ~lclk_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lclk_q <= LCLK_RST;
        end else begin
            lclk_q <= lclk_d;
        end
    end

    // ------------------------------------------------------------
    // Data and flag lines.
    // ------------------------------------------------------------
    // A released bus leaves the reference for the next decision at
    // all ones, the level that the pull-ups give the lines.
    always_comb begin
        line_d = line_q;
        flag_d = flag_q;
        if (launch && send) begin
            line_d = coded;
            flag_d = ~inv;
        end else if (launch) begin
            line_d = LINE_IDLE;
            flag_d = GRP_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_q <= LINE_IDLE;
            flag_q <= GRP_IDLE;
        end else begin
            line_q <= line_d;
            flag_q <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // Link drive.
    // ------------------------------------------------------------
    assign link.link_clk  = lclk_q;
    assign link.data_out  = line_q;
    assign link.flag_out  = flag_q;
    assign link.valid_out = valid_q;
    assign link.pos_out   = pos_q;
    assign link.neg_out   = neg_q;
    assign link.bus_oe    = oe_q;
    assign busy           = oe_q;
endmodule

// [tb/qdb_link_chk.sv]
/* Checker on the shared lines of the bus link.
 * Assumes lines change on falling link clock edges. */
`timescale 1ns/100ps
module qdb_link_chk (
    input wire logic               rst_b,
    input wire logic               link_clk,
    input wire logic               bus_oe,
    input wire qdb_pkg::qdb_word_t data_line,
    input wire qdb_pkg::qdb_grp_t  flag_line,
    input wire logic               valid_line,
    input wire qdb_pkg::qdb_grp_t  pos_line,
    input wire qdb_pkg::qdb_grp_t  neg_line
);
    import qdb_pkg::*;
    qdb_word_t prev_q, prev_d;
    qdb_beat_t beat_q, beat_d;
    // --------------------------------------------------------
    // Previous line levels and beat count.
    // --------------------------------------------------------
    always_comb begin
        prev_d = data_line;
        beat_d = valid_line ? beat_q : beat_q + 2'h1;
    end
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= LINE_IDLE;
            beat_q <= BEAT_FIRST;
        end else begin
            prev_q <= prev_d;
            beat_q <= beat_d;
        end
    end
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rst_b);
    AST_IDLE_LINES: assert property (!bus_oe |->
        data_line == LINE_IDLE && flag_line == GRP_IDLE)
        else $error("released lines not high");
    AST_VALID_DRIVEN: assert property (bus_oe |-> !valid_line)
        else $error("driven beat without valid");
    AST_WHOLE_XFER: assert property ($fell(valid_line) |->
        !valid_line [*4]) else $error("transfer under four beats");
    AST_XFER_BOUND: assert property ($rose(valid_line) |->
        beat_q == BEAT_FIRST) else $error("partial transfer");
    AST_STROBE_PHASE: assert property (!valid_line |->
        pos_line == (beat_q[0] ? 4'hF : 4'h0))
        else $error("strobe phase wrong");
    AST_STROBE_PAIR: assert property (!valid_line |->
        neg_line == ~pos_line) else $error("strobe pair mismatch");
    AST_IDLE_STROBES: assert property (valid_line |->
        pos_line == 4'hF && neg_line == 4'hF)
        else $error("strobe moved while idle");
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_inv
        AST_INV_RULE: assert property (!valid_line |->
            !flag_line[g] == ($countones(prev_q[g*GRP_W+:GRP_W] ^
            (flag_line[g] ? data_line[g*GRP_W+:GRP_W] :
            ~data_line[g*GRP_W+:GRP_W])) > 8))
            else $error("inversion decision wrong");
    end
endmodule

// [tb/quad_pumped_data_bus_inversion_tb.sv]
/* Bench joining both bus ends through the link.
 * Assumes the tx end makes the link clock from core_clk. */
`timescale 1ns/100ps
module quad_pumped_data_bus_inversion_tb;
    import qdb_pkg::*;
    typedef struct packed {qdb_word_t d; qdb_beat_t b;} qdb_row_t;
    localparam int NROW  = 12;
    localparam int LIMIT = 3000;
    logic      core_clk, rst_b, in_valid, in_ready, busy, out_valid;
    logic      full_seen;
    qdb_word_t in_data, out_data, prev_line, exp_line;
    qdb_beat_t out_beat, wb, rb;
    qdb_grp_t  exp_flag;
    int        num_errors, compares, cycles;
    qdb_word_t wq[$], rq[$];
    qdb_beat_t bq[$];
    qdb_row_t  rows [NROW] = '{
        '{64'h0000FFFF00FF0001, 2'h0}, '{64'h01FF0000FF00FFFF, 2'h1},
        '{64'hAAAA5555AAAA5555, 2'h2}, '{64'h5555AAAA5555AAAA, 2'h3},
        '{64'h123456789ABCDEF0, 2'h0}, '{64'hFFFFFFFFFFFFFFFF, 2'h1},
        '{64'h0000000000000000, 2'h2}, '{64'h00FFFF000F0FF0F0, 2'h3},
        '{64'h800000017FFEFFFE, 2'h0}, '{64'h000100030007000F, 2'h1},
        '{64'hFFFEFFFCFFF8FFF0, 2'h2}, '{64'hC3C33C3CA5A55A5A, 2'h3}};
    qdb_link_if link ();
    qdb_tx_end qdb_tx_end_inst (.core_clk(core_clk), .rst_b(rst_b),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .busy(busy), .link(link));
    qdb_rx_end qdb_rx_end_inst (.rst_b(rst_b), .link(link),
        .out_valid(out_valid), .out_data(out_data), .out_beat(out_beat));
    qdb_link_chk qdb_link_chk_inst (.rst_b(rst_b),
        .link_clk(link.link_clk), .bus_oe(link.bus_oe),
        .data_line(link.data_line), .flag_line(link.flag_line),
        .valid_line(link.valid_line), .pos_line(link.pos_line),
        .neg_line(link.neg_line));
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    // --------------------------------------------------------
    // Shared tasks.
    // --------------------------------------------------------
    task check(input qdb_word_t seen, input qdb_word_t exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task send(input qdb_word_t w);
        in_data <= w;
        in_valid <= 1'b1;
        @(posedge core_clk);
        while (!in_ready) @(posedge core_clk);
    endtask
    task drain(input string name);
        in_valid <= 1'b0;
        for (int i = 0; i < 400 && (rq.size() != 0 || busy !== 1'b0); i++)
            @(posedge core_clk);
        check(rq.size(), 0);
        check(wq.size(), 0);
        $display("test %s done", name);
    endtask
    function automatic qdb_word_t enc(input qdb_word_t w,
        input qdb_word_t prev, output qdb_grp_t fl);
        qdb_word_t ln;
        ln = ~w;
        for (int g = 0; g < NUM_GRP; g++) begin
            fl[g] = $countones(ln[g*GRP_W+:GRP_W] ^ prev[g*GRP_W+:GRP_W]) <= 8;
            if (!fl[g]) ln[g*GRP_W+:GRP_W] = w[g*GRP_W+:GRP_W];
        end
        return ln;
    endfunction
    // --------------------------------------------------------
    // Monitors and timeout.
    // --------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (in_valid && in_ready) begin
            wq.push_back(in_data);
            rq.push_back(in_data);
        end
        if (rst_b && !in_ready) full_seen = 1'b1;
        if (cycles == LIMIT) begin
            num_errors++;
            $display("unexpected at %0t: run timed out", $time);
            close_out;
        end
    end
    always @(posedge link.link_clk) begin
        if (rst_b && !link.valid_line && wq.size() > 0) begin
            exp_line = enc(wq.pop_front(), prev_line, exp_flag);
            check(link.data_line, exp_line);
            check(link.flag_line, exp_flag);
            check(link.pos_line, wb[0] ? 4'hF : 4'h0);
            check(link.neg_line, wb[0] ? 4'h0 : 4'hF);
            prev_line = exp_line;
            wb = wb + 2'h1;
        end else if (rst_b) begin
            check(link.valid_line, 1'b1);
            prev_line = LINE_IDLE;
        end
        if (rst_b && out_valid === 1'b1 && rq.size() == 0) begin
            check(out_valid, 1'b0);
        end else if (rst_b && out_valid === 1'b1) begin
            check(out_data, rq.pop_front());
            check(out_beat, bq.size() > 0 ? bq.pop_front() : rb);
            rb = rb + 2'h1;
        end
    end
    // --------------------------------------------------------
    // Main sequence.
    // --------------------------------------------------------
    initial begin
        {in_valid, full_seen, wb, rb} = '0;
        rst_b <= 1'b0;
        {num_errors, compares, cycles} = '0;
        in_data = WORD_RST;
        prev_line = LINE_IDLE;
        repeat (2) @(posedge core_clk);
        check(link.data_line, LINE_IDLE);
        check({busy, out_valid, out_beat, in_ready}, 5'h01);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < NROW; i++) begin
            bq.push_back(rows[i].b);
            send(rows[i].d);
        end
        drain("rows");
        for (int i = 0; i < 3; i++) send(rows[i].d);
        in_valid <= 1'b0;
        repeat (40) @(posedge core_clk);
        check(link.bus_oe, 1'b0);
        send(rows[3].d);
        drain("partial");
        for (int i = 0; i < 72; i++) send({4{16'(i * 16'h0F1D)}});
        check(full_seen, 1'b1);
        drain("fill");
        for (int i = 4; i < 8; i++) send(rows[i].d);
        in_valid <= 1'b0;
        wait (!link.valid_line);
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b0;
        @(posedge core_clk);
        wq.delete();
        rq.delete();
        bq.delete();
        {wb, rb} = '0;
        prev_line = LINE_IDLE;
        check(link.data_line, LINE_IDLE);
        check({busy, out_valid, link.bus_oe}, 3'h0);
        rst_b <= 1'b1;
        repeat (20) @(posedge core_clk);
        for (int i = 8; i < NROW; i++) send(rows[i].d);
        drain("reset");
        close_out;
    end
endmodule
